// ===== shared/dpl_pkg.sv
package dpl_pkg;

    // ************************************************************
    // Code and bus widths
    // ************************************************************
    localparam int CODE_W = 14;
    localparam int BYTE_W = 8;
    localparam int HI_W   = 6;

    // ************************************************************
    // Address pair decode on the byte-wide port
    // ************************************************************
    localparam logic [1:0] ADDR_DIRECT = 2'h0;
    localparam logic [1:0] ADDR_HIGH   = 2'h1;
    localparam logic [1:0] ADDR_LOW    = 2'h2;
    localparam logic [1:0] ADDR_XFER   = 2'h3;

    // ************************************************************
    // Pin timing, ns as printed for the widest temperature range
    // ************************************************************
    localparam int CLK_NS      = 20;
    localparam int WR_PULSE_NS = 240;
    localparam int SETUP_NS    = 180;
    localparam int HOLD_NS     = 30;
    localparam int WR_PULSE_CYC = (WR_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int SETUP_CYC    = (SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int HOLD_CYC     = (HOLD_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [4:0] CNT_W0 = 5'h0;

    // ************************************************************
    // Host command kinds
    // ************************************************************
    typedef enum logic [2:0] {
        CMD_DIRECT = 3'h0,
        CMD_HIGH   = 3'h1,
        CMD_LOW    = 3'h2,
        CMD_XFER   = 3'h3,
        CMD_WORD   = 3'h4,
        CMD_LOAD   = 3'h5
    } dpl_cmd_t;

    typedef struct packed {
        dpl_cmd_t          kind;
        logic [CODE_W-1:0] code;
    } dpl_req_t;

    // Byte-wide port pins
    typedef struct packed {
        logic              sel_n;
        logic              wr_n;
        logic              reg_select_hi;
        logic              reg_select_lo;
        logic [BYTE_W-1:0] data;
    } dpl_byte_pins_t;

    // Word-wide port pins
    typedef struct packed {
        logic              high_byte_select_n;
        logic              low_byte_select_n;
        logic              wr_n;
        logic              load_output_n;
        logic [CODE_W-1:0] data;
    } dpl_word_pins_t;

endpackage

// ===== logic/dpl_strobe_timer.sv
`timescale 1ns/1ps
`default_nettype none

// ************************************************************
// Phase timer: counts a phase length and pulses when it ends
// ************************************************************
module dpl_strobe_timer
(
    input  wire logic       i_clk_sys,
    input  wire logic       i_srst,
    input  wire logic       i_start,
    input  wire logic [4:0] i_len,
    output var  logic       o_done
);

    logic [4:0] cnt_r;
    logic [4:0] cnt_nxt;
    logic       done_nxt;

    // Load on start, count down, pulse done at one
    always_comb
    begin
        cnt_nxt  = cnt_r;
        done_nxt = 1'b0;
        if (i_start)
        begin
            cnt_nxt = i_len;
        end
        else if (cnt_r != dpl_pkg::CNT_W0)
        begin
            cnt_nxt  = cnt_r - 5'h1;
            done_nxt = (cnt_r == 5'h1);
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_srst)
        begin
            cnt_r  <= dpl_pkg::CNT_W0;
            o_done <= 1'b0;
        end
        else
        begin
            cnt_r  <= cnt_nxt;
            o_done <= done_nxt;
        end
    end

endmodule

`default_nettype wire

// ===== logic/dpl_host.sv
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - On the byte port a HIGH code goes as two byte writes, right-justified; DIRECT goes as one.
// - On the word port all 14 bits go at once under high and low selects.
// - Data is taken only while the write strobe is low.
// - The byte port responds only while its select is low.
// - The address pair, held through each write, picks the target.
// - On the word port a low load pulse copies inputs to the output.

module dpl_host
(
    input  wire logic                     i_clk_sys,
    input  wire logic                     i_srst,
    input  wire logic                     i_req_valid,
    input  wire dpl_pkg::dpl_req_t        i_req,
    output var  logic                     o_req_ready,
    output var  logic                     o_done,
    output var  logic [dpl_pkg::CODE_W-1:0] o_out_code,
    output var  dpl_pkg::dpl_byte_pins_t  o_byte_pins,
    output var  dpl_pkg::dpl_word_pins_t  o_word_pins
);

    // ************************************************************
    // Sequencer states
    // ************************************************************
    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_SETUP = 4'b0010,
        ST_PULSE = 4'b0100,
        ST_HOLD  = 4'b1000
    } dpl_state_t;

    dpl_state_t                    state_r;
    dpl_state_t                    state_nxt;
    dpl_pkg::dpl_req_t             req_r;
    dpl_pkg::dpl_req_t             req_nxt;
    logic                          second_r;
    logic                          second_nxt;
    logic                          tmr_start;
    logic [4:0]                    tmr_len;
    logic                          tmr_done;
    logic                          ready_nxt;
    logic                          done_nxt;
    dpl_pkg::dpl_byte_pins_t       bpins_nxt;
    dpl_pkg::dpl_word_pins_t       wpins_nxt;
    logic [dpl_pkg::CODE_W-1:0]    in_code_r;
    logic [dpl_pkg::CODE_W-1:0]    in_code_nxt;
    logic [dpl_pkg::CODE_W-1:0]    win_code_r;
    logic [dpl_pkg::CODE_W-1:0]    win_code_nxt;
    logic [dpl_pkg::CODE_W-1:0]    out_code_nxt;
    logic                          is_byte;
    logic                          is_hi_phase;
    logic [1:0]                    addr;

    dpl_strobe_timer u_timer
    (
        .i_clk_sys (i_clk_sys),
        .i_srst    (i_srst),
        .i_start   (tmr_start),
        .i_len     (tmr_len),
        .o_done    (tmr_done)
    );

    // ************************************************************
    // Decode of the current access
    // ************************************************************
    // A direct write of a code that is not all zeros or all ones would
    // be split badly by transparency, so DIRECT is sent as a single byte
    // with the code's low byte and both halves
    always_comb
    begin
        is_byte     = (req_r.kind != dpl_pkg::CMD_WORD)
                   && (req_r.kind != dpl_pkg::CMD_LOAD);
        // A direct two-step is not used; HIGH first when split
        is_hi_phase = (req_r.kind == dpl_pkg::CMD_HIGH) && !second_r;
        unique case (req_r.kind)
            dpl_pkg::CMD_DIRECT: addr = dpl_pkg::ADDR_DIRECT;
            dpl_pkg::CMD_HIGH:   addr = second_r ? dpl_pkg::ADDR_LOW
                                                 : dpl_pkg::ADDR_HIGH;
            dpl_pkg::CMD_LOW:    addr = dpl_pkg::ADDR_LOW;
            dpl_pkg::CMD_XFER:   addr = dpl_pkg::ADDR_XFER;
            default:             addr = dpl_pkg::ADDR_XFER;
        endcase
    end

    // ************************************************************
    // Sequencer: setup, strobe low, hold, then next byte or done
    // ************************************************************
    always_comb
    begin
        state_nxt    = state_r;
        req_nxt      = req_r;
        second_nxt   = second_r;
        tmr_start    = 1'b0;
        tmr_len      = 5'(dpl_pkg::SETUP_CYC);
        ready_nxt    = 1'b0;
        done_nxt     = 1'b0;
        bpins_nxt    = o_byte_pins;
        wpins_nxt    = o_word_pins;
        in_code_nxt  = in_code_r;
        win_code_nxt = win_code_r;
        out_code_nxt = o_out_code;
        unique case (state_r)
            ST_IDLE:
            begin
                ready_nxt = 1'b1;
                if (i_req_valid && o_req_ready)
                begin
                    req_nxt    = i_req;
                    second_nxt = 1'b0;
                    ready_nxt  = 1'b0;
                    tmr_start  = 1'b1;
                    state_nxt  = ST_SETUP;
                end
            end
            ST_SETUP:
            begin
                // Address, select and data settle before the strobe
                if (is_byte)
                begin
                    bpins_nxt.sel_n         = 1'b0;
                    bpins_nxt.reg_select_hi = addr[1];
                    bpins_nxt.reg_select_lo = addr[0];
                    bpins_nxt.data          = is_hi_phase
                        ? {2'h0, req_r.code[13:8]}
                        : req_r.code[7:0];
                end
                else if (req_r.kind == dpl_pkg::CMD_WORD)
                begin
                    wpins_nxt.high_byte_select_n = 1'b0;
                    wpins_nxt.low_byte_select_n  = 1'b0;
                    wpins_nxt.data               = req_r.code;
                end
                if (tmr_done)
                begin
                    tmr_start = 1'b1;
                    tmr_len   = 5'(dpl_pkg::WR_PULSE_CYC);
                    state_nxt = ST_PULSE;
                    if (req_r.kind == dpl_pkg::CMD_LOAD)
                        wpins_nxt.load_output_n = 1'b0;
                    else if (is_byte)
                        bpins_nxt.wr_n = 1'b0;
                    else
                        wpins_nxt.wr_n = 1'b0;
                end
            end
            ST_PULSE:
            begin
                if (tmr_done)
                begin
                    bpins_nxt.wr_n          = 1'b1;
                    wpins_nxt.wr_n          = 1'b1;
                    wpins_nxt.load_output_n = 1'b1;
                    tmr_start = 1'b1;
                    tmr_len   = 5'(dpl_pkg::HOLD_CYC);
                    state_nxt = ST_HOLD;
                    // Shadow of what the device now holds
                    // Byte and word devices keep separate input registers,
                    // so a word write never leaks into a byte-port copy
                    unique case (req_r.kind)
                        dpl_pkg::CMD_DIRECT:
                        begin
                            in_code_nxt  = req_r.code;
                            out_code_nxt = req_r.code;
                        end
                        dpl_pkg::CMD_HIGH:
                            if (!second_r)
                                in_code_nxt[13:8] = req_r.code[13:8];
                            else
                                in_code_nxt[7:0] = req_r.code[7:0];
                        dpl_pkg::CMD_LOW:
                            in_code_nxt[7:0] = req_r.code[7:0];
                        dpl_pkg::CMD_WORD:
                            win_code_nxt = req_r.code;
                        dpl_pkg::CMD_XFER:
                            out_code_nxt = in_code_r;
                        default:
                            out_code_nxt = win_code_r;
                    endcase
                end
            end
            ST_HOLD:
            begin
                if (tmr_done)
                begin
                    bpins_nxt.sel_n              = 1'b1;
                    wpins_nxt.high_byte_select_n = 1'b1;
                    wpins_nxt.low_byte_select_n  = 1'b1;
                    if (req_r.kind == dpl_pkg::CMD_HIGH && !second_r)
                    begin
                        second_nxt = 1'b1;
                        tmr_start  = 1'b1;
                        state_nxt  = ST_SETUP;
                    end
                    else
                    begin
                        done_nxt  = 1'b1;
                        ready_nxt = 1'b1;
                        state_nxt = ST_IDLE;
                    end
                end
            end
        endcase
    end

    // ************************************************************
    // Registers; strobes and selects idle high so the device ignores the bus
    // ************************************************************
    always_ff @(posedge i_clk_sys)
    begin
        if (i_srst)
        begin
            state_r     <= ST_IDLE;
            req_r       <= '0;
            second_r    <= 1'b0;
            o_req_ready <= 1'b0;
            o_done      <= 1'b0;
            in_code_r   <= '0;
            win_code_r  <= '0;
            o_out_code  <= '0;
            o_byte_pins <= '{sel_n: 1'b1, wr_n: 1'b1, reg_select_hi: 1'b0,
                             reg_select_lo: 1'b0, data: 8'h00};
            o_word_pins <= '{high_byte_select_n: 1'b1,
                             low_byte_select_n: 1'b1, wr_n: 1'b1,
                             load_output_n: 1'b1, data: 14'h0000};
        end
        else
        begin
            state_r     <= state_nxt;
            req_r       <= req_nxt;
            second_r    <= second_nxt;
            o_req_ready <= ready_nxt;
            o_done      <= done_nxt;
            in_code_r   <= in_code_nxt;
            win_code_r  <= win_code_nxt;
            o_out_code  <= out_code_nxt;
            o_byte_pins <= bpins_nxt;
            o_word_pins <= wpins_nxt;
        end
    end

endmodule

`default_nettype wire

// ===== verif/dpl_host_assertions.sv
`timescale 1ns/1ps
`default_nettype none

// ************************************************************
// Pin-level checks on the parallel load host
// ************************************************************
module dpl_host_assertions
(
    input wire logic                       i_clk_sys,
    input wire logic                       i_srst,
    input wire logic                       i_req_valid,
    input wire dpl_pkg::dpl_req_t          i_req,
    input wire logic                       o_req_ready,
    input wire logic                       o_done,
    input wire logic [dpl_pkg::CODE_W-1:0] o_out_code,
    input wire dpl_pkg::dpl_byte_pins_t    o_byte_pins,
    input wire dpl_pkg::dpl_word_pins_t    o_word_pins
);
    dpl_pkg::dpl_req_t          req_r, req_nxt;
    logic [dpl_pkg::CODE_W-1:0] out_r, out_nxt;
    logic [4:0]                 cnt_r, cnt_nxt;
    logic                       take;
    logic [1:0]                 addr;

    // Keep the request in flight, since pins only make sense against it
    always_comb
    begin
        take    = i_req_valid && o_req_ready;
        addr    = {o_byte_pins.reg_select_hi, o_byte_pins.reg_select_lo};
        req_nxt = take ? i_req : req_r;
        out_nxt = take ? o_out_code : out_r;
        cnt_nxt = o_byte_pins.wr_n ? 5'h0 : cnt_r + 5'h1;
    end

    // Register the helpers
    always_ff @(posedge i_clk_sys)
    begin
        req_r <= i_srst ? '0 : req_nxt;
        out_r <= i_srst ? '0 : out_nxt;
        cnt_r <= i_srst ? 5'h0 : cnt_nxt;
    end

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_srst);

    sequence take_s;
        take;
    endsequence
    sequence byte_wr_s;
        !o_byte_pins.wr_n;
    endsequence

    ready_drop_a: assert property (take_s |=> !o_req_ready)
        else $error("ready stayed high after a take");
    done_bound_a: assert property (take_s |=> ##[1:120] o_done)
        else $error("request did not complete");
    wr_sel_a: assert property (byte_wr_s |-> !o_byte_pins.sel_n)
        else $error("byte strobe low without select");
    wr_steady_a: assert property (byte_wr_s ##1 byte_wr_s |-> $stable(o_byte_pins))
        else $error("byte pins moved during strobe");
    // The phase timer's registered done stretches each phase by one cycle
    strobe_width_a: assert property ($rose(o_byte_pins.wr_n) |->
        cnt_r == 5'(dpl_pkg::WR_PULSE_CYC + 1))
        else $error("byte strobe width wrong");
    addr_kind_a: assert property ((byte_wr_s and
        (addr != dpl_pkg::ADDR_HIGH)) |->
        o_byte_pins.data == req_r.code[7:0] && (req_r.kind == dpl_pkg::CMD_HIGH
        ? addr == dpl_pkg::ADDR_LOW : addr == req_r.kind[1:0]))
        else $error("address or low byte wrong");
    hi_byte_a: assert property ((byte_wr_s and
        (addr == dpl_pkg::ADDR_HIGH)) |->
        o_byte_pins.data == {2'h0, req_r.code[13:8]})
        else $error("high byte wrong");
    word_bus_a: assert property (!o_word_pins.wr_n |-> o_word_pins.load_output_n
        && !o_word_pins.high_byte_select_n && !o_word_pins.low_byte_select_n
        && o_word_pins.data == req_r.code)
        else $error("word write wrong");
    load_alone_a: assert property (!o_word_pins.load_output_n |->
        o_word_pins.wr_n && req_r.kind == dpl_pkg::CMD_LOAD)
        else $error("load strobe out of place");
    out_hold_a: assert property (o_done && req_r.kind inside {dpl_pkg::CMD_HIGH,
        dpl_pkg::CMD_LOW, dpl_pkg::CMD_WORD} |-> o_out_code == out_r)
        else $error("output code moved without a load");
    direct_out_a: assert property (o_done && req_r.kind == dpl_pkg::CMD_DIRECT
        |-> o_out_code == req_r.code)
        else $error("direct load code wrong");
endmodule

bind dpl_host dpl_host_assertions u_chk
(
    .i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_req_valid(i_req_valid),
    .i_req(i_req), .o_req_ready(o_req_ready), .o_done(o_done),
    .o_out_code(o_out_code), .o_byte_pins(o_byte_pins),
    .o_word_pins(o_word_pins)
);

`default_nettype wire

// ===== verif/dpl_dev_model.sv
`timescale 1ns/1ps
`default_nettype none

// ************************************************************
// Converter model with the byte-wide and the word-wide port
// ************************************************************
module dpl_dev_model
(
    input  wire dpl_pkg::dpl_byte_pins_t    i_byte,
    input  wire dpl_pkg::dpl_word_pins_t    i_word,
    output var  logic [dpl_pkg::CODE_W-1:0] o_byte_dac,
    output var  logic [dpl_pkg::CODE_W-1:0] o_word_dac
);
    logic [dpl_pkg::CODE_W-1:0] b_in;
    logic [dpl_pkg::CODE_W-1:0] w_in;

    // Level latches with no reset: contents are unknown until written
    always @*
        if (!i_byte.sel_n && !i_byte.wr_n)
            case ({i_byte.reg_select_hi, i_byte.reg_select_lo})
                dpl_pkg::ADDR_DIRECT:
                    {b_in, o_byte_dac} = {2{i_byte.data[5:0], i_byte.data}};
                dpl_pkg::ADDR_HIGH: b_in[13:8] = i_byte.data[5:0];
                dpl_pkg::ADDR_LOW:  b_in[7:0] = i_byte.data;
                default:            o_byte_dac = b_in;
            endcase

    // Each select opens its half; the load strobe ignores the write strobe
    always @*
    begin
        if (!i_word.wr_n && !i_word.high_byte_select_n)
            w_in[13:8] = i_word.data[13:8];
        if (!i_word.wr_n && !i_word.low_byte_select_n)
            w_in[7:0] = i_word.data[7:0];
        if (!i_word.load_output_n)
            o_word_dac = w_in;
    end
endmodule

`default_nettype wire

// ===== verif/dac_parallel_load_port_test.sv
`timescale 1ns/1ps
`default_nettype none

// ************************************************************
// Self-checking bench for the parallel load host
// ************************************************************
module dac_parallel_load_port_test;
    logic                       i_clk_sys;
    logic                       i_srst;
    logic                       i_req_valid;
    dpl_pkg::dpl_req_t          i_req;
    logic                       o_req_ready;
    logic                       o_done;
    logic [dpl_pkg::CODE_W-1:0] o_out_code;
    dpl_pkg::dpl_byte_pins_t    o_byte_pins;
    dpl_pkg::dpl_word_pins_t    o_word_pins;
    logic [dpl_pkg::CODE_W-1:0] bdac_seen, wdac_seen;
    logic [dpl_pkg::CODE_W-1:0] bin, bdac, win, wdac, outc;
    logic [41:0]                exp_q[$];
    logic [31:0]                rnd;
    logic [2:0]                 kv;
    int                         miscompares;
    int                         checks;

    dpl_host uut
    (
        .i_clk_sys   (i_clk_sys),
        .i_srst      (i_srst),
        .i_req_valid (i_req_valid),
        .i_req       (i_req),
        .o_req_ready (o_req_ready),
        .o_done      (o_done),
        .o_out_code  (o_out_code),
        .o_byte_pins (o_byte_pins),
        .o_word_pins (o_word_pins)
    );

    dpl_dev_model u_dev
    (
        .i_byte     (o_byte_pins),
        .i_word     (o_word_pins),
        .o_byte_dac (bdac_seen),
        .o_word_dac (wdac_seen)
    );

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic check(input logic [41:0] seen, input logic [41:0] exp);
        checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    task automatic summarize();
        if (miscompares == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Valid stays up between requests, so back-to-back takes are exercised
    task automatic send(input dpl_pkg::dpl_cmd_t k, input logic [13:0] c);
        int n;
        n = 0;
        i_req_valid = 1'b1;
        i_req = {k, c};
        while (o_req_ready !== 1'b1 && n < 300)
        begin
            @(negedge i_clk_sys);
            n++;
        end
        // A host that never comes back to idle is a failure
        if (n >= 300)
            miscompares++;
        case (k)
            dpl_pkg::CMD_DIRECT: {bin, bdac, outc} = {c, c, c};
            dpl_pkg::CMD_HIGH:   bin = c;
            dpl_pkg::CMD_LOW:    bin[7:0] = c[7:0];
            dpl_pkg::CMD_XFER:   {bdac, outc} = {bin, bin};
            dpl_pkg::CMD_WORD:   win = c;
            default:             {wdac, outc} = {win, win};
        endcase
        exp_q.push_back({outc, bdac, wdac});
        @(negedge i_clk_sys);
    endtask

    // 50 MHz system clock
    initial
    begin
        i_clk_sys = 1'b0;
        forever #10 i_clk_sys = ~i_clk_sys;
    end

    // Each completion is judged against the oldest note
    always @(negedge i_clk_sys)
        if (o_done === 1'b1)
            check({o_out_code, bdac_seen, wdac_seen},
                  (exp_q.size() != 0) ? exp_q.pop_front() : 'x);

    // Cut a hang short; the whole run needs a small part of this span
    initial
    begin
        repeat (20000) @(posedge i_clk_sys);
        miscompares++;
        summarize();
    end

    // Directed openings, then random traffic over every command kind
    initial
    begin
        i_srst = 1'b1;
        i_req_valid = 1'b0;
        i_req = '0;
        rnd = 32'h0001_5111;
        repeat (4) @(negedge i_clk_sys);
        check(42'({o_out_code, o_req_ready, o_done, o_byte_pins.wr_n,
              o_byte_pins.sel_n, o_word_pins.wr_n,
              o_word_pins.load_output_n}), 42'h0000f);
        i_srst = 1'b0;
        send(dpl_pkg::CMD_DIRECT, 14'h3fff);
        send(dpl_pkg::CMD_WORD, 14'h2a5c);
        send(dpl_pkg::CMD_LOAD, 14'h0000);
        send(dpl_pkg::CMD_DIRECT, 14'h0000);
        send(dpl_pkg::CMD_HIGH, 14'h3c81);
        send(dpl_pkg::CMD_LOW, 14'h00a5);
        send(dpl_pkg::CMD_XFER, 14'h1111);
        repeat (48)
        begin
            rnd = lfsr_next(rnd);
            kv = rnd[18:16];
            if (kv > 3'h5)
                kv = kv - 3'h4;
            send(dpl_pkg::dpl_cmd_t'(kv),
                 (kv == 3'h0) ? {14{rnd[3]}} : rnd[13:0]);
        end
        i_req_valid = 1'b0;
        for (int i = 0; i < 300 && exp_q.size() != 0; i++)
            @(negedge i_clk_sys);
        // Notes left over mean completions went missing
        if (exp_q.size() != 0)
            miscompares++;
        summarize();
    end
endmodule

`default_nettype wire
